// File: core/mad_opcode_table.sv
// Combinational opcode table: operation, operands, length and cycle count
`timescale 1ns/100ps
`default_nettype none
`include "mad_params.svh"
module mad_opcode_table (
	// Opcode and width controls
	input wire logic [7:0] opcode_i,
	input wire logic wide_arith_select_i,
	input wire logic long_divide_select_i,
	// Decoded result
	output mad_pkg::mad_dec_s dec_o
);
	logic [4:0] hi;
	logic [2:0] lo;
	mad_pkg::mad_loc_e arg;
	logic arg_ok;
	logic [1:0] arg_len;
	assign hi = opcode_i[7:3];
	assign lo = opcode_i[2:0];

	// Operand kind from the low bits, shared by the accumulator-group rows
	always_comb begin
		arg_ok = 1'b1;
		arg_len = 2'h1;
		if (lo[2:1] == 2'b11 || opcode_i[3]) begin
			arg = opcode_i[3] ? mad_pkg::MAD_LOC_WREG : mad_pkg::MAD_LOC_INDIRECT;
		end else if (lo == 3'h5) begin
			arg = mad_pkg::MAD_LOC_DIRECT;
			arg_len = 2'h2;
		end else if (lo == 3'h4) begin
			arg = mad_pkg::MAD_LOC_IMM;
			arg_len = 2'h2;
		end else begin
			arg = mad_pkg::MAD_LOC_NONE;
			arg_ok = 1'b0;
		end
	end

	// Main table; unlisted opcodes come back illegal
	always_comb begin
		dec_o = '0;
		dec_o.cyc = {2'h0, `MAD_CYC_SHORT};
		dec_o.len = 2'h1;
		unique casez (opcode_i)
			8'b0010_1???, 8'h24, 8'h25, 8'h26, 8'h27: begin
				dec_o.op = mad_pkg::MAD_OP_ADD;
			end
			8'b0011_1???, 8'h34, 8'h35, 8'h36, 8'h37: begin
				dec_o.op = mad_pkg::MAD_OP_SUM_WITH_CARRY;
			end
			8'b1001_1???, 8'h94, 8'h95, 8'h96, 8'h97: begin
				dec_o.op = mad_pkg::MAD_OP_SUBTRACT_WITH_BORROW;
			end
			8'b0101_1???, 8'h54, 8'h55, 8'h56, 8'h57: begin
				dec_o.op = mad_pkg::MAD_OP_BITWISE_AND;
			end
			8'b0100_1???, 8'h44, 8'h45, 8'h46, 8'h47: begin
				dec_o.op = mad_pkg::MAD_OP_BITWISE_OR;
			end
			8'b0110_1???, 8'h64, 8'h65, 8'h66, 8'h67: begin
				dec_o.op = mad_pkg::MAD_OP_BITWISE_XOR;
			end
			8'b1110_1???, 8'he5, 8'he6, 8'he7, 8'h74: begin
				dec_o.op = mad_pkg::MAD_OP_MOVE;
			end
			8'b1100_1???, 8'hc5, 8'hc6, 8'hc7: begin
				dec_o.op = mad_pkg::MAD_OP_BYTE_EXCHANGE;
			end
			default: begin
				dec_o.op = mad_pkg::MAD_OP_NONE;
			end
		endcase
		if (dec_o.op != mad_pkg::MAD_OP_NONE) begin
			dec_o.legal = arg_ok;
			dec_o.len = arg_len;
			dec_o.dst = mad_pkg::MAD_LOC_ACC;
			dec_o.src = (opcode_i == 8'h74) ? mad_pkg::MAD_LOC_IMM : arg;
		end else begin
			dec_o.legal = 1'b1;
			unique casez (opcode_i)
				// direct and, or, xor; acc or immediate source
				8'h52, 8'h42, 8'h62: begin
					dec_o.op = (hi[2:0] == 3'h2) ? mad_pkg::MAD_OP_BITWISE_AND :
						(hi[2:0] == 3'h0) ? mad_pkg::MAD_OP_BITWISE_OR :
						mad_pkg::MAD_OP_BITWISE_XOR;
					{dec_o.dst, dec_o.src, dec_o.len} =
						{mad_pkg::MAD_LOC_DIRECT, mad_pkg::MAD_LOC_ACC, 2'h2};
				end
				8'h53, 8'h43, 8'h63: begin
					dec_o.op = (hi[2:0] == 3'h2) ? mad_pkg::MAD_OP_BITWISE_AND :
						(hi[2:0] == 3'h0) ? mad_pkg::MAD_OP_BITWISE_OR :
						mad_pkg::MAD_OP_BITWISE_XOR;
					{dec_o.dst, dec_o.src, dec_o.len} =
						{mad_pkg::MAD_LOC_DIRECT, mad_pkg::MAD_LOC_IMM, 2'h3};
					dec_o.cyc = {2'h0, `MAD_CYC_MID};
				end
				8'h23, 8'h33, 8'h03, 8'h13: begin
					dec_o.op = (opcode_i == 8'h23) ? mad_pkg::MAD_OP_ROTATE_LEFT :
						(opcode_i == 8'h33) ? mad_pkg::MAD_OP_ROTATE_LEFT_CARRY :
						(opcode_i == 8'h03) ? mad_pkg::MAD_OP_ROTATE_RIGHT :
						mad_pkg::MAD_OP_ROTATE_RIGHT_CARRY;
					{dec_o.dst, dec_o.src} = {mad_pkg::MAD_LOC_ACC, mad_pkg::MAD_LOC_ACC};
				end
				8'b1111_1???, 8'b1010_1???, 8'b0111_1???: begin
					dec_o.op = mad_pkg::MAD_OP_MOVE;
					dec_o.dst = mad_pkg::MAD_LOC_WREG;
					dec_o.src = (hi == 5'h1f) ? mad_pkg::MAD_LOC_ACC :
						(hi == 5'h15) ? mad_pkg::MAD_LOC_DIRECT : mad_pkg::MAD_LOC_IMM;
					dec_o.len = (hi == 5'h1f) ? 2'h1 : 2'h2;
					if (hi == 5'h15) begin
						dec_o.cyc = {2'h0, `MAD_CYC_MID};
					end
				end
				8'hf5, 8'b1000_1???, 8'h86, 8'h87, 8'h85, 8'h75: begin
					dec_o.op = mad_pkg::MAD_OP_MOVE;
					dec_o.dst = mad_pkg::MAD_LOC_DIRECT;
					dec_o.len = (opcode_i == 8'h85 || opcode_i == 8'h75) ? 2'h3 : 2'h2;
					dec_o.src = (opcode_i == 8'hf5) ? mad_pkg::MAD_LOC_ACC :
						opcode_i[3] ? mad_pkg::MAD_LOC_WREG :
						(opcode_i == 8'h85) ? mad_pkg::MAD_LOC_DIRECT :
						(opcode_i == 8'h75) ? mad_pkg::MAD_LOC_IMM : mad_pkg::MAD_LOC_INDIRECT;
					if (opcode_i != 8'hf5) begin
						dec_o.cyc = {2'h0, `MAD_CYC_MID};
					end
				end
				8'hf6, 8'hf7, 8'ha6, 8'ha7, 8'h76, 8'h77: begin
					dec_o.op = mad_pkg::MAD_OP_MOVE;
					dec_o.dst = mad_pkg::MAD_LOC_INDIRECT;
					dec_o.src = (hi == 5'h1e) ? mad_pkg::MAD_LOC_ACC :
						(hi == 5'h14) ? mad_pkg::MAD_LOC_DIRECT : mad_pkg::MAD_LOC_IMM;
					dec_o.len = (hi == 5'h1e) ? 2'h1 : 2'h2;
					if (hi == 5'h14) begin
						dec_o.cyc = {2'h0, `MAD_CYC_MID};
					end
				end
				`MAD_OP_DATA_POINTER_16_LOAD: begin
					dec_o.op = mad_pkg::MAD_OP_DATA_POINTER_16_LOAD;
					{dec_o.dst, dec_o.src, dec_o.len} =
						{mad_pkg::MAD_LOC_NONE, mad_pkg::MAD_LOC_IMM, 2'h3};
					dec_o.cyc = {2'h0, `MAD_CYC_MID};
				end
				`MAD_OP_TABLE_DATA_POINTER_16, `MAD_OP_TABLE_PC: begin
					dec_o.op = mad_pkg::MAD_OP_CODE_TABLE_READ;
					{dec_o.dst, dec_o.src} = {mad_pkg::MAD_LOC_ACC, mad_pkg::MAD_LOC_CODE};
					dec_o.cyc = {2'h0, `MAD_CYC_LONG};
				end
				8'he2, 8'he3, 8'he0, 8'hf2, 8'hf3, 8'hf0: begin
					dec_o.op = opcode_i[4] ? mad_pkg::MAD_OP_EXT_WRITE : mad_pkg::MAD_OP_EXT_READ;
					dec_o.dst = opcode_i[4] ? mad_pkg::MAD_LOC_EXT : mad_pkg::MAD_LOC_ACC;
					dec_o.src = opcode_i[4] ? mad_pkg::MAD_LOC_ACC : mad_pkg::MAD_LOC_EXT;
					dec_o.cyc = {2'h0, `MAD_CYC_LONG};
				end
				8'hc0, 8'hd0: begin
					dec_o.op = opcode_i[4] ? mad_pkg::MAD_OP_POP : mad_pkg::MAD_OP_PUSH;
					{dec_o.dst, dec_o.src, dec_o.len} =
						{mad_pkg::MAD_LOC_DIRECT, mad_pkg::MAD_LOC_DIRECT, 2'h2};
					dec_o.cyc = {2'h0, `MAD_CYC_MID};
				end
				8'hd6, 8'hd7: begin
					dec_o.op = mad_pkg::MAD_OP_NIBBLE_EXCHANGE;
					{dec_o.dst, dec_o.src} = {mad_pkg::MAD_LOC_ACC, mad_pkg::MAD_LOC_INDIRECT};
				end
				// width selects set multiply and divide time
				`MAD_OP_MUL, `MAD_OP_DIV: begin
					dec_o.op = opcode_i[5] ? mad_pkg::MAD_OP_MULTIPLY : mad_pkg::MAD_OP_DIVIDE;
					{dec_o.dst, dec_o.src} = {mad_pkg::MAD_LOC_ACC, mad_pkg::MAD_LOC_ACC};
					if (!wide_arith_select_i) begin
						dec_o.cyc = {2'h0, `MAD_MUL_CYC_NARROW};
					end else if (!opcode_i[5] && long_divide_select_i) begin
						dec_o.cyc = `MAD_DIV_CYC_LONG;
					end else begin
						dec_o.cyc = {1'b0, `MAD_MUL_CYC_WIDE};
					end
				end
				default: begin
					dec_o.legal = 1'b0;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: shared/mad_params.svh
// Opcode, register-select and timing constants for the ALU and move decoder
`ifndef MAD_PARAMS_SVH
`define MAD_PARAMS_SVH
`define MAD_CYC_SHORT 4'h2
`define MAD_CYC_MID 4'h4
`define MAD_CYC_LONG 4'h8
`define MAD_MUL_CYC_NARROW 4'h8
`define MAD_MUL_CYC_WIDE 5'h10
`define MAD_DIV_CYC_LONG 6'h20
`define MAD_OP_DATA_POINTER_16_LOAD 8'h90
`define MAD_OP_TABLE_DATA_POINTER_16 8'h93
`define MAD_OP_TABLE_PC 8'h83
`define MAD_OP_MUL 8'ha4
`define MAD_OP_DIV 8'h84
`define MAD_REG_SEL_MSB 2
`endif

// File: shared/mad_pkg.sv
// Types shared by the ALU and move decoder
package mad_pkg;
	typedef enum logic [4:0] {
		MAD_OP_NONE = 5'h00,
		MAD_OP_ADD = 5'h01,
		MAD_OP_SUM_WITH_CARRY = 5'h02,
		MAD_OP_SUBTRACT_WITH_BORROW = 5'h03,
		MAD_OP_BITWISE_AND = 5'h04,
		MAD_OP_BITWISE_OR = 5'h05,
		MAD_OP_BITWISE_XOR = 5'h06,
		MAD_OP_ROTATE_LEFT = 5'h07,
		MAD_OP_ROTATE_LEFT_CARRY = 5'h08,
		MAD_OP_ROTATE_RIGHT = 5'h09,
		MAD_OP_ROTATE_RIGHT_CARRY = 5'h0a,
		MAD_OP_MOVE = 5'h0b,
		MAD_OP_DATA_POINTER_16_LOAD = 5'h0c,
		MAD_OP_CODE_TABLE_READ = 5'h0d,
		MAD_OP_EXT_READ = 5'h0e,
		MAD_OP_EXT_WRITE = 5'h0f,
		MAD_OP_PUSH = 5'h10,
		MAD_OP_POP = 5'h11,
		MAD_OP_BYTE_EXCHANGE = 5'h12,
		MAD_OP_NIBBLE_EXCHANGE = 5'h13,
		MAD_OP_MULTIPLY = 5'h14,
		MAD_OP_DIVIDE = 5'h15
	} mad_op_e;
	typedef enum logic [2:0] {
		MAD_LOC_NONE = 3'h0,
		MAD_LOC_ACC = 3'h1,
		MAD_LOC_WREG = 3'h2,
		MAD_LOC_DIRECT = 3'h3,
		MAD_LOC_INDIRECT = 3'h4,
		MAD_LOC_IMM = 3'h5,
		MAD_LOC_EXT = 3'h6,
		MAD_LOC_CODE = 3'h7
	} mad_loc_e;
	typedef enum logic [1:0] {
		MAD_ST_IDLE = 2'h0,
		MAD_ST_OPERAND = 2'h1,
		MAD_ST_EXEC = 2'h2
	} mad_state_e;
	typedef struct packed {
		mad_op_e op;
		mad_loc_e dst;
		mad_loc_e src;
		logic [1:0] len;
		logic [5:0] cyc;
		logic legal;
	} mad_dec_s;
endpackage

// File: core/mad_decoder.sv
// Instruction decoder and sequencer for the ALU and data-move opcode groups
`timescale 1ns/100ps
`default_nettype none
`include "mad_params.svh"
module mad_decoder #(
	parameter int unsigned MAX_CYCLES = 32
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Program memory fetch path
	output logic fetch_req_o,
	input wire logic fetch_valid_i,
	input wire logic [7:0] fetch_data_i,
	// Arithmetic width selects
	input wire logic wide_arith_select_i,
	input wire logic long_divide_select_i,
	// Decoded instruction to the datapath
	output mad_pkg::mad_op_e op_o,
	output mad_pkg::mad_loc_e dst_o,
	output mad_pkg::mad_loc_e src_o,
	output logic [2:0] working_register_o,
	output logic indirect_register_operand_o,
	output logic [7:0] operand1_o,
	output logic [7:0] operand2_o,
	output logic [1:0] length_o,
	output logic [5:0] cycles_o,
	// Sequencing status
	output logic busy_o,
	output logic commit_o,
	output logic illegal_o
);
	// Elaboration check: the counter must hold the longest divide
	if (MAX_CYCLES < 32 || MAX_CYCLES > 63) begin : g_bad_max
		$error("mad_decoder: MAX_CYCLES must be 32..63");
	end

	typedef struct packed {
		mad_pkg::mad_state_e state;
		mad_pkg::mad_dec_s dec;
		logic [7:0] opcode;
		logic [7:0] operand1;
		logic [7:0] operand2;
		logic [1:0] got;
		logic [5:0] count;
		logic fetch_req;
		logic busy;
		logic commit;
		logic illegal;
	} mad_core_s;

	mad_core_s cur;
	mad_core_s next_cur;
	mad_pkg::mad_dec_s table_dec;
	logic rst_meta;
	logic rst_sync_n;

	// Reset release through two flops so removal is clean against clk_i
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			rst_meta <= 1'b0;
			rst_sync_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_sync_n <= rst_meta;
		end
	end

	// Table lookup on the byte arriving; only sampled when it is an opcode
	mad_opcode_table u_table (
		.opcode_i(fetch_data_i),
		.wide_arith_select_i(wide_arith_select_i),
		.long_divide_select_i(long_divide_select_i),
		.dec_o(table_dec)
	);

	// Sequencer: opcode fetch, operand fetch, then hold until the count expires
	always_comb begin
		next_cur = cur;
		next_cur.commit = 1'b0;
		next_cur.illegal = 1'b0;
		unique case (cur.state)
			mad_pkg::MAD_ST_IDLE: begin
				next_cur.fetch_req = 1'b1;
				next_cur.busy = 1'b0;
				if (cur.fetch_req && fetch_valid_i) begin
					// length and cycles latched per opcode
					next_cur.opcode = fetch_data_i;
					next_cur.dec = table_dec;
					next_cur.got = 2'h1;
					// opcode fetch is cycle one of the count
					next_cur.count = 6'h1;
					next_cur.busy = 1'b1;
					next_cur.operand1 = 8'h00;
					next_cur.operand2 = 8'h00;
					if (!table_dec.legal) begin
						// Unknown opcodes are flagged and skipped as one-byte, no commit
						next_cur.illegal = 1'b1;
						next_cur.busy = 1'b0;
					end else if (table_dec.len == 2'h1) begin
						next_cur.state = mad_pkg::MAD_ST_EXEC;
						next_cur.fetch_req = 1'b0;
					end else begin
						next_cur.state = mad_pkg::MAD_ST_OPERAND;
					end
				end
			end
			mad_pkg::MAD_ST_OPERAND: begin
				// Cycles spent stalled on fetch still count toward the total
				next_cur.count = cur.count + 6'h1;
				if (fetch_valid_i) begin
					// operand bytes gathered in order before commit
					if (cur.got == 2'h1) begin
						next_cur.operand1 = fetch_data_i;
					end else begin
						next_cur.operand2 = fetch_data_i;
					end
					next_cur.got = cur.got + 2'h1;
					if (cur.got + 2'h1 == cur.dec.len) begin
						next_cur.state = mad_pkg::MAD_ST_EXEC;
						next_cur.fetch_req = 1'b0;
					end
				end
			end
			mad_pkg::MAD_ST_EXEC: begin
				// commit once the documented count has elapsed
				if (cur.count >= cur.dec.cyc) begin
					next_cur.commit = 1'b1;
					next_cur.busy = 1'b0;
					next_cur.state = mad_pkg::MAD_ST_IDLE;
					next_cur.fetch_req = 1'b1;
				end else begin
					next_cur.count = cur.count + 6'h1;
				end
			end
			default: begin
				next_cur.state = mad_pkg::MAD_ST_IDLE;
			end
		endcase
	end

	// Single state register
	always_ff @(posedge clk_i or negedge rst_sync_n) begin
		if (!rst_sync_n) begin
			cur <= '0;
		end else begin
			cur <= next_cur;
		end
	end

	// Outputs straight from the state register
	assign fetch_req_o = cur.fetch_req;
	assign op_o = cur.dec.op;
	assign dst_o = cur.dec.dst;
	assign src_o = cur.dec.src;
	// register number from the low opcode bits
	assign working_register_o = cur.opcode[`MAD_REG_SEL_MSB:0];
	assign indirect_register_operand_o = cur.opcode[0];
	assign operand1_o = cur.operand1;
	assign operand2_o = cur.operand2;
	assign length_o = cur.dec.len;
	assign cycles_o = cur.dec.cyc;
	assign busy_o = cur.busy;
	assign commit_o = cur.commit;
	assign illegal_o = cur.illegal;
endmodule
`default_nettype wire

// File: verif/mad_fetch_model.sv
// Program memory model serving bytes to the decoder fetch path
`timescale 1ns/100ps
`default_nettype none
module mad_fetch_model (
	// Clock, reset and stall control
	input wire logic clk_i,
	input wire logic mem_nrst_i,
	input wire logic stall_i,
	// Fetch handshake
	input wire logic fetch_req_i,
	output logic fetch_valid_o,
	output logic [7:0] fetch_data_o
);
	typedef struct packed {logic [9:0] pc; logic [7:0] last;} mad_mem_s;
	logic [7:0] mem [1024];
	mad_mem_s s;
	mad_mem_s next_s;
	// An idle or stalled bus shows the inverse of the last byte, so stale data never matches
	assign fetch_valid_o = fetch_req_i && !stall_i;
	assign fetch_data_o = fetch_valid_o ? mem[s.pc] : ~s.last;
	// Step the pointer on every byte the decoder takes
	always_comb begin
		next_s = s;
		if (fetch_valid_o) begin
			next_s.pc = s.pc + 10'h001;
			next_s.last = mem[s.pc];
		end
	end
	always_ff @(posedge clk_i or negedge mem_nrst_i) begin
		if (!mem_nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
endmodule
`default_nettype wire

// File: verif/mad_decoder_assertions.sv
// Concurrent checks on the ALU and move decoder ports
`timescale 1ns/100ps
`default_nettype none
module mad_decoder_assertions (
	// Clock and reset
	input wire logic clk_i,
	input wire logic nrst_i,
	// Fetch path and width selects
	input wire logic fetch_req_o,
	input wire logic fetch_valid_i,
	input wire logic [7:0] fetch_data_i,
	input wire logic wide_arith_select_i,
	input wire logic long_divide_select_i,
	// Decoded outputs and status
	input wire mad_pkg::mad_op_e op_o,
	input wire logic [2:0] working_register_o,
	input wire logic indirect_register_operand_o,
	input wire logic [1:0] length_o,
	input wire logic [5:0] cycles_o,
	input wire logic busy_o,
	input wire logic commit_o,
	input wire logic illegal_o
);
	typedef struct packed {logic [7:0] since; logic [1:0] nb; logic stl;} mad_seen_s;
	mad_seen_s s;
	mad_seen_s next_s;
	logic take;
	logic opb;
	// Opcode and operand takes as the decoder sees them
	assign take = fetch_req_o && fetch_valid_i && !busy_o;
	assign opb = fetch_req_o && fetch_valid_i && busy_o;
	// Cycles and operand bytes since the opcode; a stall excuses a late commit
	always_comb begin
		next_s = s;
		if (take) begin
			next_s = '{since: 8'h01, nb: 2'h0, stl: 1'b0};
		end else begin
			next_s.since = (s.since == 8'hff) ? s.since : s.since + 8'h01;
			next_s.nb = s.nb + {1'b0, opb};
			next_s.stl = s.stl || (busy_o && fetch_req_o && !fetch_valid_i);
		end
	end
	always_ff @(posedge clk_i or negedge nrst_i) begin
		if (!nrst_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!nrst_i);
	AST_COMMIT_TIME: assert property (commit_o && !s.stl |-> s.since == {2'h0, cycles_o} + 8'h01)
		else $error("commit off the stated cycle count");
	AST_OPERANDS_FIRST: assert property (commit_o |-> s.nb == length_o - 2'h1)
		else $error("commit before all operand bytes");
	AST_FETCH_LEVEL: assert property (busy_o |-> fetch_req_o == (s.nb < length_o - 2'h1))
		else $error("fetch request disagrees with bytes still owed");
	AST_LEN_CYC_RANGE: assert property (busy_o && !(op_o inside {mad_pkg::MAD_OP_MULTIPLY,
		mad_pkg::MAD_OP_DIVIDE}) |-> length_o != 2'h0 && cycles_o inside {[6'h01:6'h08]})
		else $error("length or cycles out of range");
	AST_WREG_FIELD: assert property (take |=> busy_o |-> {5'h00, working_register_o} ==
		($past(fetch_data_i) & 8'h07) && indirect_register_operand_o == $past(fetch_data_i[0]))
		else $error("register select not from low opcode bits");
	AST_COMMIT_PULSE: assert property (commit_o |=> !commit_o)
		else $error("commit on two adjacent cycles");
	AST_LONG_MOVES: assert property (busy_o && op_o inside {mad_pkg::MAD_OP_CODE_TABLE_READ,
		mad_pkg::MAD_OP_EXT_READ, mad_pkg::MAD_OP_EXT_WRITE} |-> length_o == 2'h1 && cycles_o == 6'h08)
		else $error("table or external move not one byte eight cycles");
	AST_MUL_TIME: assert property (busy_o && op_o == mad_pkg::MAD_OP_MULTIPLY |->
		cycles_o == (wide_arith_select_i ? 6'h10 : 6'h08))
		else $error("multiply time wrong for width");
	AST_DIV_TIME: assert property (busy_o && op_o == mad_pkg::MAD_OP_DIVIDE |-> cycles_o ==
		(!wide_arith_select_i ? 6'h08 : long_divide_select_i ? 6'h20 : 6'h10))
		else $error("divide time wrong for selects");
	cover property (commit_o && length_o == 2'h3);
	cover property (commit_o && s.stl);
	cover property (illegal_o);
endmodule
bind mad_decoder mad_decoder_assertions u_chk (.clk_i(clk_i), .nrst_i(nrst_i),
	.fetch_req_o(fetch_req_o), .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
	.wide_arith_select_i(wide_arith_select_i), .long_divide_select_i(long_divide_select_i),
	.op_o(op_o), .working_register_o(working_register_o),
	.indirect_register_operand_o(indirect_register_operand_o), .length_o(length_o),
	.cycles_o(cycles_o), .busy_o(busy_o), .commit_o(commit_o), .illegal_o(illegal_o));
`default_nettype wire

// File: verif/mcu_alu_move_decoder_test.sv
// Self-checking bench for the ALU and move decoder
`timescale 1ns/100ps
`default_nettype none
module mcu_alu_move_decoder_test;
	logic clk_i = 1'b0;
	logic nrst_i = 1'b0;
	logic mem_nrst = 1'b0;
	logic stall = 1'b0;
	logic wide = 1'b0;
	logic lng = 1'b0;
	logic fetch_req_o, fetch_valid_i, indirect_register_operand_o, busy_o, commit_o, illegal_o;
	logic [7:0] fetch_data_i, operand1_o, operand2_o;
	logic [2:0] working_register_o;
	logic [1:0] length_o;
	logic [5:0] cycles_o;
	mad_pkg::mad_op_e op_o;
	mad_pkg::mad_loc_e dst_o;
	mad_pkg::mad_loc_e src_o;
	int p = 0;
	int bad_count = 0;
	int check_count = 0;
	// First opcode, last opcode, length, cycles
	logic [23:0] rows [44] = '{24'h242522, 24'h262f12, 24'h343522, 24'h363f12, 24'h949522,
		24'h969f12, 24'h525222, 24'h535334, 24'h545522, 24'h565f12, 24'h424222, 24'h434334,
		24'h444522, 24'h464f12, 24'h626222, 24'h636334, 24'h646522, 24'h666f12, 24'h232312,
		24'h333312, 24'h030312, 24'h131312, 24'he5e522, 24'he6ef12, 24'hf5f522, 24'hf6ff12,
		24'h747422, 24'h757534, 24'h767f22, 24'h858534, 24'h868f24, 24'ha6af24, 24'he2e318,
		24'he0e018, 24'hf2f318, 24'hf0f018, 24'hc5c522, 24'hc6cf12, 24'hd6d712, 24'hc0c024,
		24'hd0d024, 24'h909034, 24'h939318, 24'h838318};
	always #2 clk_i = ~clk_i;
	mad_decoder #(.MAX_CYCLES(32)) uut (.clk_i(clk_i), .nrst_i(nrst_i),
		.fetch_req_o(fetch_req_o), .fetch_valid_i(fetch_valid_i), .fetch_data_i(fetch_data_i),
		.wide_arith_select_i(wide), .long_divide_select_i(lng), .op_o(op_o), .dst_o(dst_o),
		.src_o(src_o),
		.working_register_o(working_register_o),
		.indirect_register_operand_o(indirect_register_operand_o), .operand1_o(operand1_o),
		.operand2_o(operand2_o), .length_o(length_o), .cycles_o(cycles_o), .busy_o(busy_o),
		.commit_o(commit_o), .illegal_o(illegal_o));
	mad_fetch_model u_mem (.clk_i(clk_i), .mem_nrst_i(mem_nrst), .stall_i(stall),
		.fetch_req_i(fetch_req_o), .fetch_valid_o(fetch_valid_i), .fetch_data_o(fetch_data_i));
	task automatic chk(input logic ok, input string msg);
		check_count++;
		if (ok !== 1'b1) begin
			bad_count++;
			$display("BAD %0t %s", $time, msg);
		end
	endtask
	// Place the instruction in memory and wait for its opcode to be taken
	task automatic take(input logic [7:0] o, input logic [1:0] len);
		int n;
		u_mem.mem[p] = o;
		u_mem.mem[p + 1] = o ^ 8'h5a;
		u_mem.mem[p + 2] = o ^ 8'ha5;
		p = p + len;
		n = 0;
		while (!(fetch_req_o && fetch_valid_i && !busy_o) && n < 40) begin
			@(negedge clk_i);
			n++;
		end
	endtask
	// Run one instruction; a stall holds back operand bytes for six cycles
	task automatic go(input logic [7:0] o, input logic [1:0] len, input logic [5:0] cyc,
		input logic stl);
		int n;
		take(o, len);
		@(negedge clk_i);
		stall = stl;
		chk(length_o === len && cycles_o === cyc, "length or cycles");
		chk(working_register_o === o[2:0] && indirect_register_operand_o === o[0], "reg");
		n = 1;
		while (commit_o !== 1'b1 && n < 60) begin
			@(negedge clk_i);
			n++;
			if (n == 7) stall = 1'b0;
		end
		chk(stl ? n > cyc + 1 : n == cyc + 1, "commit timing");
		chk(operand1_o === (len > 2'h1 ? o ^ 8'h5a : 8'h00) &&
			operand2_o === (len > 2'h2 ? o ^ 8'ha5 : 8'h00), "operands");
	endtask
	task automatic wrap_up;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	// Main sequence: table rows, then selects, illegal, stall and reset cases
	initial begin
		@(negedge clk_i);
		chk(!fetch_req_o && !busy_o && !commit_o && !illegal_o && length_o === 2'h0, "reset");
		@(negedge clk_i);
		nrst_i = 1'b1;
		mem_nrst = 1'b1;
		for (int i = 0; i < 44; i++) begin
			for (int o = rows[i][23:16]; o <= rows[i][15:8]; o++) begin
				go(8'(o), rows[i][5:4], {2'h0, rows[i][3:0]}, 1'b0);
			end
		end
		$display("table rows done at %0t", $time);
		go(8'ha4, 2'h1, 6'h08, 1'b0);
		go(8'h84, 2'h1, 6'h08, 1'b0);
		wide = 1'b1;
		go(8'ha4, 2'h1, 6'h10, 1'b0);
		go(8'h84, 2'h1, 6'h10, 1'b0);
		lng = 1'b1;
		go(8'h84, 2'h1, 6'h20, 1'b0);
		// Decoded fields stand after commit until the next opcode is taken
		chk(op_o === mad_pkg::MAD_OP_DIVIDE && dst_o === mad_pkg::MAD_LOC_ACC, "div op");
		$display("width selects done at %0t", $time);
		take(8'h04, 2'h1);
		@(negedge clk_i);
		chk(illegal_o === 1'b1 && busy_o === 1'b0 && commit_o === 1'b0, "illegal");
		go(8'h53, 2'h3, 6'h04, 1'b1);
		$display("illegal and stall done at %0t", $time);
		take(8'h93, 2'h1);
		repeat (3) @(negedge clk_i);
		nrst_i = 1'b0;
		@(negedge clk_i);
		chk(busy_o === 1'b0 && fetch_req_o === 1'b0 && commit_o === 1'b0, "mid reset");
		nrst_i = 1'b1;
		go(8'h24, 2'h2, 6'h02, 1'b0);
		chk(op_o === mad_pkg::MAD_OP_ADD && src_o === mad_pkg::MAD_LOC_IMM, "add op");
		go(8'hf0, 2'h1, 6'h08, 1'b0);
		chk(op_o === mad_pkg::MAD_OP_EXT_WRITE && dst_o === mad_pkg::MAD_LOC_EXT, "ext op");
		$display("reset case done at %0t", $time);
		wrap_up;
	end
	// Hang guard, well past the several hundred cycles the sequence needs
	initial begin
		#60000;
		bad_count++;
		$display("BAD %0t watchdog expired", $time);
		wrap_up;
	end
endmodule
`default_nettype wire
